// ### rtl/cps_pkg.sv
// constants, encodings and carriers of the control processor sequencer
// assumes one 250 MHz system clock and one clock enable for all state
package cps_pkg;
  localparam int PM_DEPTH = 2048;
  localparam int PM_AW = 11;
  localparam int IW = 22;
  localparam int RW = 16;
  localparam int NREG = 16;
  localparam int RAW = 4;
  localparam int XAW = 8;
  localparam int IMM_W = 14;
  localparam int SYS_CLK_NS = 4;
  localparam int MASTER_NS = 160;
  // whole system clocks per master cycle, rounded up
  localparam int MASTER_CYC = (MASTER_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(MASTER_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_RESET = 6'h00;
  localparam logic [PM_AW-1:0] PC_RESET = 11'h000;
  localparam logic [PM_AW-1:0] PC_STEP1 = 11'h001;
  localparam logic [PM_AW-1:0] PC_STEP2 = 11'h002;
  localparam logic [RW-1:0] REG_RESET = 16'h0000;
  localparam logic [RW-1:0] ONE = 16'h0001;
  localparam logic [IW-1:0] NOP_WORD = 22'h000000;
  // sign bit of a register value
  localparam int SIGN_BIT = RW - 1;

  typedef enum logic [3:0] {
    CPS_OP_NOP = 4'h0,
    CPS_OP_PIPE_ADDR = 4'h1,
    CPS_OP_LOAD_IMM = 4'h2,
    CPS_OP_REG_EXPR = 4'h3,
    CPS_OP_SKIP_NONNEG = 4'h4,
    CPS_OP_JUMP = 4'h5,
    CPS_OP_JUMP_DEFER = 4'h6,
    CPS_OP_EXT_MOVE = 4'h7
  } cps_op_e;

  typedef enum logic [4:0] {
    CPS_F_MOV = 5'h00, CPS_F_NEG = 5'h01, CPS_F_INC = 5'h02,
    CPS_F_DEC = 5'h03, CPS_F_ADD = 5'h04, CPS_F_SUB = 5'h05,
    CPS_F_RSUB = 5'h06, CPS_F_ADD1 = 5'h07, CPS_F_SUB1 = 5'h08,
    CPS_F_RSUB1 = 5'h09, CPS_F_ADDQ = 5'h0A, CPS_F_SUBQ = 5'h0B,
    CPS_F_ADDQ1 = 5'h0C, CPS_F_SUBQ1 = 5'h0D, CPS_F_NEGQ = 5'h0E,
    CPS_F_COMP = 5'h10, CPS_F_AND = 5'h11, CPS_F_OR = 5'h12,
    CPS_F_XOR = 5'h13, CPS_F_BIT_CLEAR = 5'h14, CPS_F_XNOR = 5'h15,
    CPS_F_ANDQ = 5'h16, CPS_F_ORQ = 5'h17, CPS_F_XORQ = 5'h18
  } cps_form_e;

  typedef enum logic [1:0] {
    CPS_ST_RUN = 2'b00,
    CPS_ST_FLUSH = 2'b01,
    CPS_ST_XWAIT = 2'b10,
    CPS_ST_XDONE = 2'b11
  } cps_state_e;

  // instruction word, msb first: op, mod, form, rs, quan, rd
  typedef struct packed {
    logic [3:0] op;
    logic mod;
    logic [4:0] form;
    logic [RAW-1:0] rs;
    logic [3:0] quan;
    logic [RAW-1:0] rd;
  } cps_instr_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [XAW-1:0] addr;
    logic [RW-1:0] wdata;
  } cps_xreq_s;

  typedef struct packed {
    logic start;
    logic [RW-1:0] src;
    logic [RW-1:0] dst;
  } cps_pipe_s;
endpackage

// ### rtl/cps_pmem.sv
// instruction store: 2048 words of 22 bits, read by address
// assumes the loader writes only while the sequencer is stopped
`timescale 1ns/1ps
`default_nettype none
module cps_pmem (
  input wire logic sys_clk,
  input wire logic ce,
  input wire logic load_en,
  input wire logic [cps_pkg::PM_AW-1:0] load_addr,
  input wire logic [cps_pkg::IW-1:0] load_data,
  input wire logic [cps_pkg::PM_AW-1:0] rd_addr,
  output logic [cps_pkg::IW-1:0] rd_data
);
  logic [cps_pkg::IW-1:0] mem [cps_pkg::PM_DEPTH]; // 2048 x 22

  // only the loader port writes; execution has no path
  always_ff @(posedge sys_clk) begin
    if (ce && load_en) begin
      mem[load_addr] <= load_data;
    end
  end

  // combinational read keeps fetch inside one master cycle
  assign rd_data = mem[rd_addr]; // absolute address, no base added
endmodule
`default_nettype wire

// ### rtl/cps_alu.sv
// expression unit of the register instructions
// assumes operands come straight from the general register file
`timescale 1ns/1ps
`default_nettype none
module cps_alu (
  input wire logic [4:0] form,
  input wire logic [cps_pkg::RW-1:0] rs_val,
  input wire logic [cps_pkg::RW-1:0] rd_val,
  input wire logic [3:0] quan,
  output logic [cps_pkg::RW-1:0] result,
  output logic arith_ok,
  output logic logic_ok
);
  logic [cps_pkg::RW-1:0] q;
  assign q = {12'h000, quan};

  // arithmetic and logical forms; unknown codes flag neither
  always_comb begin
    result = cps_pkg::REG_RESET;
    arith_ok = 1'b1;
    logic_ok = 1'b0;
    unique case (form)
      cps_pkg::CPS_F_MOV: result = rs_val;
      cps_pkg::CPS_F_NEG: result = -rs_val;
      cps_pkg::CPS_F_INC: result = rs_val + cps_pkg::ONE;
      cps_pkg::CPS_F_DEC: result = rs_val - cps_pkg::ONE;
      cps_pkg::CPS_F_ADD: result = rd_val + rs_val;
      cps_pkg::CPS_F_SUB: result = rd_val - rs_val;
      cps_pkg::CPS_F_RSUB: result = rs_val - rd_val;
      cps_pkg::CPS_F_ADD1: result = rs_val + rd_val + cps_pkg::ONE;
      cps_pkg::CPS_F_SUB1: result = rd_val - rs_val - cps_pkg::ONE;
      cps_pkg::CPS_F_RSUB1: result = rs_val - rd_val - cps_pkg::ONE;
      cps_pkg::CPS_F_ADDQ: result = rs_val + q;
      cps_pkg::CPS_F_SUBQ: result = rs_val - q;
      cps_pkg::CPS_F_ADDQ1: result = rs_val + cps_pkg::ONE + q;
      cps_pkg::CPS_F_SUBQ1: result = rs_val - cps_pkg::ONE - q;
      cps_pkg::CPS_F_NEGQ: result = q - rs_val;
      default: begin
        // logical forms are not arithmetic, so skips refuse them
        arith_ok = 1'b0;
        logic_ok = 1'b1;
        unique case (form)
          cps_pkg::CPS_F_COMP: result = ~rs_val;
          cps_pkg::CPS_F_AND: result = rs_val & rd_val;
          cps_pkg::CPS_F_OR: result = rs_val | rd_val;
          cps_pkg::CPS_F_XOR: result = rs_val ^ rd_val;
          cps_pkg::CPS_F_BIT_CLEAR: result = rs_val & ~rd_val;
          cps_pkg::CPS_F_XNOR: result = ~(rs_val ^ rd_val);
          cps_pkg::CPS_F_ANDQ: result = rs_val & q;
          cps_pkg::CPS_F_ORQ: result = rs_val | q;
          cps_pkg::CPS_F_XORQ: result = rs_val ^ q;
          default: logic_ok = 1'b0;
        endcase
      end
    endcase
  end
endmodule
`default_nettype wire

// ### rtl/cps_seq.sv
// control processor sequencer: fetch, address counter, execution
// assumes pipeline and external registers answer on the ports below
//
// Behaviour
// - instructions run one at a time, each on whole master cycles
// - external accesses, jumps and busy pipeline starts take extra cycles; register ops take one
// - deferred jump lets the next instruction run, then lands; no bubble
// - instruction store is 2048 words of 22 bits, 11-bit address
// - program addresses are absolute, no relocation in hardware
// - address counter advances by one after each instruction
// - taken branch loads the address counter with the target
// - no write path from execution into the instruction store
// - all-zero word does nothing but advance the counter
// - pipeline address instruction starts pipeline, may update register
// - load-immediate writes the instruction constant to a register
// - register expression writes one arithmetic or logical result to destination
// - nonnegative skip evaluates arithmetic form, may store, skips
`timescale 1ns/1ps
`default_nettype none
module cps_seq (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic run,
  input wire logic load_we,
  input wire logic [cps_pkg::PM_AW-1:0] load_addr,
  input wire logic [cps_pkg::IW-1:0] load_data,
  input wire logic pipe_busy,
  output cps_pkg::cps_pipe_s pipe_cmd,
  output cps_pkg::cps_xreq_s xreq,
  input wire logic ext_ack,
  input wire logic [cps_pkg::RW-1:0] ext_rdata,
  output logic [cps_pkg::PM_AW-1:0] program_address_counter,
  output logic master_tick
);
  logic [cps_pkg::IW-1:0] ins_word;
  cps_pkg::cps_instr_s ins;
  cps_pkg::cps_op_e op;
  logic [cps_pkg::PM_AW-1:0] pc_r, pc_nxt, dtgt_r, dtgt_nxt;
  logic [cps_pkg::PM_AW-1:0] pc_inc1, pc_inc2, seq_pc, tgt;
  logic [cps_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  cps_pkg::cps_state_e st_r, st_nxt;
  logic dfr_r, dfr_nxt, tick, step;
  cps_pkg::cps_xreq_s xreq_r, xreq_nxt;
  cps_pkg::cps_pipe_s pipe_r, pipe_nxt;
  logic [cps_pkg::RW-1:0] rf_r [cps_pkg::NREG];
  logic [cps_pkg::RW-1:0] rs_val, rd_val, alu_res, rf_wd, imm16;
  logic rf_we, alu_arith, alu_logic;

  function automatic logic [cps_pkg::PM_AW-1:0] pc_add(
    input logic [cps_pkg::PM_AW-1:0] base,
    input logic [cps_pkg::PM_AW-1:0] n);
    pc_add = base + n;
  endfunction

  // loader writes only while stopped, so no instruction can write
  cps_pmem u_pmem (
    .sys_clk(sys_clk),
    .ce(ce),
    .load_en(load_we && !run),
    .load_addr(load_addr),
    .load_data(load_data),
    .rd_addr(pc_r),
    .rd_data(ins_word)
  );

  cps_alu u_alu (
    .form(ins.form),
    .rs_val(rs_val),
    .rd_val(rd_val),
    .quan(ins.quan),
    .result(alu_res),
    .arith_ok(alu_arith),
    .logic_ok(alu_logic)
  );

  // field decode of the fetched word
  assign ins = cps_pkg::cps_instr_s'(ins_word);
  assign op = cps_pkg::cps_op_e'(ins.op);
  assign rs_val = rf_r[ins.rs];
  assign rd_val = rf_r[ins.rd];
  assign imm16 = {2'b00, ins_word[cps_pkg::IMM_W+3:4]};
  assign tgt = {ins.form[2:0], ins.rs, ins.quan}; // absolute
  assign pc_inc1 = pc_add(pc_r, cps_pkg::PC_STEP1);
  assign pc_inc2 = pc_add(pc_r, cps_pkg::PC_STEP2);
  // a pending deferred target replaces the plain increment
  assign seq_pc = dfr_r ? dtgt_r : pc_inc1;

  // master cycle divider: execution lands on its tick; an external answer lands when it comes
  assign tick = run && (cnt_r == cps_pkg::CNT_LAST);
  assign step = tick && (st_r == cps_pkg::CPS_ST_RUN);
  always_comb begin
    cnt_nxt = cnt_r + 6'h01;
    if (!run || tick) begin
      cnt_nxt = cps_pkg::CNT_RESET;
    end
  end

  // sequencing and execution, one decision per master tick
  always_comb begin
    pc_nxt = pc_r;
    st_nxt = st_r;
    dfr_nxt = dfr_r;
    dtgt_nxt = dtgt_r;
    xreq_nxt = xreq_r;
    pipe_nxt = pipe_r;
    pipe_nxt.start = 1'b0;
    rf_we = 1'b0;
    rf_wd = alu_res;
    if (tick) begin
      unique case (st_r)
        cps_pkg::CPS_ST_FLUSH: st_nxt = cps_pkg::CPS_ST_RUN; // refetch
        cps_pkg::CPS_ST_XWAIT: st_nxt = st_r; // held for the ack
        cps_pkg::CPS_ST_XDONE: begin
          // access finished: the following instruction may go
          st_nxt = cps_pkg::CPS_ST_RUN;
          pc_nxt = seq_pc;
          dfr_nxt = 1'b0;
        end
        cps_pkg::CPS_ST_RUN: begin
          pc_nxt = seq_pc; // advance by one, or land a pending deferred target
          dfr_nxt = 1'b0;
          case (op)
            cps_pkg::CPS_OP_PIPE_ADDR: begin
              if (pipe_busy) begin
                // pipeline not ready: repeat this instruction next cycle
                pc_nxt = pc_r;
                dfr_nxt = dfr_r;
              end else begin
                pipe_nxt.start = 1'b1;
                pipe_nxt.src = rd_val;
                pipe_nxt.dst = rs_val;
                rf_we = ins.mod && alu_arith;
              end
            end
            cps_pkg::CPS_OP_LOAD_IMM: begin
              rf_we = 1'b1;
              rf_wd = imm16;
            end
            cps_pkg::CPS_OP_REG_EXPR: begin
              rf_we = alu_arith || alu_logic;
            end
            cps_pkg::CPS_OP_SKIP_NONNEG: begin
              // logical forms are refused here: no store, no skip
              rf_we = ins.mod && alu_arith;
              if (alu_arith && !alu_res[cps_pkg::SIGN_BIT] && !dfr_r) begin
                pc_nxt = pc_inc2;
              end
            end
            cps_pkg::CPS_OP_JUMP: begin
              // a pending deferred target wins over a jump in its shadow
              if (!dfr_r) begin
                pc_nxt = tgt;
                st_nxt = cps_pkg::CPS_ST_FLUSH; // costs one more cycle
              end
            end
            cps_pkg::CPS_OP_JUMP_DEFER: begin
              dfr_nxt = 1'b1; // the next instruction still runs
              dtgt_nxt = ins.mod ? rd_val[cps_pkg::PM_AW-1:0] : tgt;
            end
            cps_pkg::CPS_OP_EXT_MOVE: begin
              // this access, like a busy pipeline start, may stretch over cycles
              pc_nxt = pc_r;
              dfr_nxt = dfr_r;
              st_nxt = cps_pkg::CPS_ST_XWAIT;
              xreq_nxt.valid = 1'b1;
              xreq_nxt.write = ins.mod;
              xreq_nxt.addr = {ins.rs, ins.quan};
              xreq_nxt.wdata = rd_val;
            end
            default: pc_nxt = seq_pc; // unused codes behave as no-op
          endcase
        end
      endcase
    end
    // answer may come at any system clock while waiting
    if (st_r == cps_pkg::CPS_ST_XWAIT && ext_ack) begin
      xreq_nxt.valid = 1'b0;
      st_nxt = cps_pkg::CPS_ST_XDONE;
      rf_we = !xreq_r.write;
      rf_wd = ext_rdata;
    end
  end

  // state registers, frozen while ce is low
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= cps_pkg::CNT_RESET;
      pc_r <= cps_pkg::PC_RESET;
      dtgt_r <= cps_pkg::PC_RESET;
      st_r <= cps_pkg::CPS_ST_RUN;
      dfr_r <= 1'b0;
      xreq_r <= '0;
      pipe_r <= '0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
      pc_r <= pc_nxt;
      dtgt_r <= dtgt_nxt;
      st_r <= st_nxt;
      dfr_r <= dfr_nxt;
      xreq_r <= xreq_nxt;
      pipe_r <= pipe_nxt;
    end
  end

  // general register file; a write lands with the instruction's tick, an external read with its ack
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < cps_pkg::NREG; i++) begin
        rf_r[i] <= cps_pkg::REG_RESET;
      end
    end else if (ce && rf_we) begin
      rf_r[ins.rd] <= rf_wd;
    end
  end

  assign program_address_counter = pc_r;
  assign xreq = xreq_r;
  assign pipe_cmd = pipe_r;
  assign master_tick = tick;

  AST_NOP_ADVANCES: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    ce && step && ins_word == cps_pkg::NOP_WORD && !dfr_r
    |-> !rf_we ##1 pc_r == pc_add($past(pc_r), cps_pkg::PC_STEP1))
    else $error("no-op did not advance by one");

  AST_SKIP_PLUS_TWO: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    ce && step && op == cps_pkg::CPS_OP_SKIP_NONNEG && alu_arith
    && !alu_res[cps_pkg::SIGN_BIT] && !dfr_r
    |=> pc_r == pc_add($past(pc_r), cps_pkg::PC_STEP2))
    else $error("taken skip did not add two");

  AST_LOGIC_NO_SKIP: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    ce && step && op == cps_pkg::CPS_OP_SKIP_NONNEG && !alu_arith && !dfr_r
    |=> pc_r == pc_add($past(pc_r), cps_pkg::PC_STEP1))
    else $error("skip taken on a logical form");

  AST_JUMP_LOADS: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    ce && step && op == cps_pkg::CPS_OP_JUMP && !dfr_r
    |=> pc_r == $past(tgt) && st_r == cps_pkg::CPS_ST_FLUSH)
    else $error("jump target not loaded");

  AST_FLUSH_ONE: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    ce && tick && st_r == cps_pkg::CPS_ST_FLUSH
    |=> st_r == cps_pkg::CPS_ST_RUN && $stable(pc_r))
    else $error("flush held or moved the address");

  AST_DEFER_SHADOW: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    ce && step && op == cps_pkg::CPS_OP_JUMP_DEFER && !dfr_r
    |=> dfr_r && st_r == cps_pkg::CPS_ST_RUN
    && pc_r == $past(pc_inc1))
    else $error("deferred jump did not run its shadow");

  AST_DEFER_LANDS: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    ce && step && dfr_r && op != cps_pkg::CPS_OP_EXT_MOVE
    && !(op == cps_pkg::CPS_OP_PIPE_ADDR && pipe_busy)
    |=> pc_r == $past(dtgt_r))
    else $error("deferred target not taken");

  AST_WAIT_HOLDS: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    st_r == cps_pkg::CPS_ST_XWAIT && !ext_ack |=> $stable(pc_r))
    else $error("address moved during external access");

  AST_XDONE_MOVES: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    ce && tick && st_r == cps_pkg::CPS_ST_XDONE
    |=> st_r == cps_pkg::CPS_ST_RUN && !dfr_r
    && pc_r == ($past(dfr_r) ? $past(dtgt_r)
    : pc_add($past(pc_r), cps_pkg::PC_STEP1)))
    else $error("finished access did not release the next instruction");

  AST_REQ_ONLY_WAIT: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    xreq_r.valid |-> st_r == cps_pkg::CPS_ST_XWAIT)
    else $error("external request outside wait");

  AST_TICK_ONLY: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    !(ce && tick) |=> $stable(pc_r))
    else $error("address changed off the master tick");

  // a deferred target may equal the current address, so compare exactly
  AST_ONE_CYCLE: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    ce && step && (op == cps_pkg::CPS_OP_REG_EXPR
    || op == cps_pkg::CPS_OP_LOAD_IMM)
    |=> st_r == cps_pkg::CPS_ST_RUN
    && pc_r == ($past(dfr_r) ? $past(dtgt_r)
    : pc_add($past(pc_r), cps_pkg::PC_STEP1)))
    else $error("register instruction took extra cycles");

  AST_LOAD_IMM: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    ce && step && op == cps_pkg::CPS_OP_LOAD_IMM
    |=> rf_r[$past(ins.rd)] == $past(imm16))
    else $error("immediate not written");

  AST_PIPE_START: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    ce && step && op == cps_pkg::CPS_OP_PIPE_ADDR && !pipe_busy
    |=> pipe_r.start && pipe_r.src == $past(rd_val)
    && pipe_r.dst == $past(rs_val))
    else $error("pipeline start missing");
endmodule
`default_nettype wire

// ### verification/cps_far_model.sv
// far side: pipeline busy flag and external word store
// assumes the sequencer's clock and reset are shared with it
`timescale 1ns/1ps
`default_nettype none
module cps_far_model (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire cps_pkg::cps_pipe_s pipe_cmd,
  input wire cps_pkg::cps_xreq_s xreq,
  output logic pipe_busy,
  output logic ext_ack,
  output logic [cps_pkg::RW-1:0] ext_rdata
);
  logic [cps_pkg::RW-1:0] mem [256];
  int bcnt;
  int acnt;
  // random busy span so ticks fall both inside and after it
  assign pipe_busy = (bcnt != 0);
  // ack after a random wait, zero included; idle data toggles
  // so a stale read value can never look right
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bcnt <= 0;
      acnt <= 0;
      ext_ack <= 1'b0;
      ext_rdata <= 16'h0000;
      for (int i = 0; i < 256; i++) mem[i] <= 16'(i * 997 + 5);
    end else begin
      if (pipe_cmd.start === 1'b1) bcnt <= $urandom_range(90, 0);
      else if (bcnt != 0) bcnt <= bcnt - 1;
      ext_ack <= 1'b0;
      ext_rdata <= ~ext_rdata;
      if (xreq.valid === 1'b1 && !ext_ack && acnt != 0) acnt <= acnt - 1;
      if (xreq.valid === 1'b1 && !ext_ack && acnt == 0) begin
        ext_ack <= 1'b1;
        acnt <= $urandom_range(60, 0);
        if (xreq.write) mem[xreq.addr] <= xreq.wdata;
        else ext_rdata <= mem[xreq.addr];
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/tb.sv
// bench: random program run in lockstep with an instruction model
// assumes cps_far_model answers the pipeline and external ports
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic run = 1'b0;
  logic load_we = 1'b0;
  logic [10:0] load_addr = 11'h000;
  logic [21:0] load_data = 22'h000000;
  logic pipe_busy;
  logic ext_ack;
  logic [15:0] ext_rdata;
  cps_pkg::cps_pipe_s pipe_cmd;
  cps_pkg::cps_xreq_s xreq;
  logic [10:0] pc;
  logic master_tick;
  int err_count = 0;
  int n_tests = 0;
  int ticks = 0;
  int gap = 0;
  int xst = 0;
  bit active = 0;
  bit ce_drop = 0;
  logic ce = 1'b1;
  bit flush;
  bit dpend;
  logic xv_q = 1'b0;
  logic [21:0] pm [2048];
  logic [15:0] r [16];
  logic [10:0] epc;
  logic [10:0] dtgt;
  cps_pkg::cps_instr_s xw;
  logic [31:0] exp_p [$];
  logic [31:0] exp_x [$];
  // zero skip, widest constant, write-out, deferred with jump in shadow
  logic [21:0] pro [7] = '{22'h080001, 22'h100100, 22'h000000,
    22'h0BFFF2, 22'h1E0FF2, 22'h180100, 22'h147FF0};

  initial forever #2 sys_clk = ~sys_clk;

  // second phase drops the enable now and then to check the freeze
  always @(posedge sys_clk) ce <= !ce_drop || ($urandom_range(7, 0) != 0);

  cps_seq dut (.sys_clk(sys_clk), .resetn(resetn), .ce(ce), .run(run),
    .load_we(load_we), .load_addr(load_addr), .load_data(load_data),
    .pipe_busy(pipe_busy), .pipe_cmd(pipe_cmd), .xreq(xreq),
    .ext_ack(ext_ack), .ext_rdata(ext_rdata),
    .program_address_counter(pc), .master_tick(master_tick));

  cps_far_model far (.sys_clk(sys_clk), .resetn(resetn),
    .pipe_cmd(pipe_cmd), .xreq(xreq), .pipe_busy(pipe_busy),
    .ext_ack(ext_ack), .ext_rdata(ext_rdata));

  task automatic chk(input string what, input logic [31:0] e,
      input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // expression result with arith and logical class bits on top
  function automatic logic [17:0] alu(input logic [4:0] f,
      input logic [15:0] s, input logic [15:0] d, input logic [3:0] qn);
    logic [15:0] q;
    q = {12'h000, qn};
    case (f)
      5'h00: return {2'b10, s};
      5'h01: return {2'b10, 16'h0000 - s};
      5'h02: return {2'b10, s + 16'h0001};
      5'h03: return {2'b10, s - 16'h0001};
      5'h04: return {2'b10, d + s};
      5'h05: return {2'b10, d - s};
      5'h06: return {2'b10, s - d};
      5'h07: return {2'b10, s + d + 16'h0001};
      5'h08: return {2'b10, d - s - 16'h0001};
      5'h09: return {2'b10, s - d - 16'h0001};
      5'h0A: return {2'b10, s + q};
      5'h0B: return {2'b10, s - q};
      5'h0C: return {2'b10, s + 16'h0001 + q};
      5'h0D: return {2'b10, s - 16'h0001 - q};
      5'h0E: return {2'b10, q - s};
      5'h10: return {2'b01, ~s};
      5'h11: return {2'b01, s & d};
      5'h12: return {2'b01, s | d};
      5'h13: return {2'b01, s ^ d};
      5'h14: return {2'b01, s & ~d};
      5'h15: return {2'b01, ~(s ^ d)};
      5'h16: return {2'b01, s & q};
      5'h17: return {2'b01, s | q};
      5'h18: return {2'b01, s ^ q};
      default: return 18'h00000;
    endcase
  endfunction

  // one master cycle of the instruction model
  task automatic step();
    cps_pkg::cps_instr_s w;
    logic [17:0] a;
    logic [10:0] nx;
    bit sh;
    if (xst == 1) return;
    if (xst == 2) begin
      // a deferred target held over the access lands now
      xst = 0;
      epc = dpend ? dtgt : epc + 11'h001;
      dpend = 0;
      return;
    end
    if (flush) begin
      flush = 0;
      return;
    end
    w = cps_pkg::cps_instr_s'(pm[epc]);
    nx = epc + 11'h001;
    sh = dpend;
    dpend = 0;
    a = alu(w.form, r[w.rs], r[w.rd], w.quan);
    case (w.op)
      4'h1: begin
        if (pipe_busy) nx = epc;
        else exp_p.push_back({r[w.rd], r[w.rs]});
        if (!pipe_busy && w.mod && a[17]) r[w.rd] = a[15:0];
      end
      4'h2: r[w.rd] = {2'b00, pm[epc][17:4]};
      4'h3: if (a[17] || a[16]) r[w.rd] = a[15:0];
      4'h4: begin
        if (a[17] && w.mod) r[w.rd] = a[15:0];
        if (a[17] && !a[15]) nx = epc + 11'h002;
      end
      4'h5: begin
        nx = pm[epc][14:4];
        flush = 1;
      end
      4'h6: begin
        dpend = 1;
        dtgt = w.mod ? r[w.rd][10:0] : pm[epc][14:4];
      end
      4'h7: begin
        exp_x.push_back({7'h00, w.mod, w.rs, w.quan, r[w.rd]});
        xw = w;
        xst = 1;
        nx = epc;
      end
      default: ;
    endcase
    // a shadow op that holds its address keeps the target pending
    if (sh && (xst == 1 || (w.op == 4'h1 && pipe_busy))) dpend = 1;
    else if (sh) begin
      nx = dtgt;
      flush = 0;
    end
    epc = nx;
  endtask

  // compare outputs against the model at every enabled clock;
  // a frozen clock moves nothing, held pulses are seen once
  always @(posedge sys_clk) begin
    logic [31:0] e;
    if (active && ce === 1'b1) begin
      gap = gap + 1;
      if (pipe_cmd.start === 1'b1) begin
        e = 32'hFFFFFFFF;
        if (exp_p.size() > 0) e = exp_p.pop_front();
        chk("pipe", e, {pipe_cmd.src, pipe_cmd.dst});
      end
      if (xreq.valid === 1'b1 && !xv_q) begin
        e = 32'hFFFFFFFF;
        if (exp_x.size() > 0) e = exp_x.pop_front();
        chk("xreq", e, {7'h00, xreq.write, xreq.addr, xreq.wdata});
      end
      xv_q = xreq.valid;
      if (master_tick === 1'b1) begin
        if (ticks > 0) chk("gap", 32'h28, 32'(gap));
        gap = 0;
        ticks = ticks + 1;
        chk("pc", 32'(epc), 32'(pc));
        step();
      end
      if (xst == 1 && xreq.valid === 1'b1 && ext_ack === 1'b1) begin
        if (!xw.mod) r[xw.rd] = ext_rdata;
        xst = 2;
      end
    end
  end

  task automatic run_phase(input int ph);
    active = 0;
    resetn <= 1'b0;
    repeat (12) @(posedge sys_clk);
    run <= 1'b0;
    resetn <= 1'b1;
    for (int i = 0; i < 2048 && ph == 0; i++) begin
      @(posedge sys_clk);
      load_we <= 1'b1;
      load_addr <= 11'(i);
      load_data <= pm[i];
    end
    @(posedge sys_clk);
    load_we <= 1'b0;
    epc = 11'h000;
    flush = 0;
    dpend = 0;
    xst = 0;
    ticks = 0;
    foreach (r[i]) r[i] = 16'h0000;
    exp_p.delete();
    exp_x.delete();
    run <= 1'b1;
    active = 1;
    ce_drop = (ph == 1);
    wait (ticks >= 300);
    // store writes while running must not land
    for (int i = 0; i < 8 && ph == 0; i++) begin
      @(posedge sys_clk);
      load_we <= 1'b1;
      load_addr <= 11'(i);
      load_data <= ~pm[i];
    end
    @(posedge sys_clk);
    load_we <= 1'b0;
    wait (ticks >= 600);
    $display("phase %0d done, %0d ticks, %0d errors", ph, ticks, err_count);
  endtask

  initial begin
    int seed;
    int op;
    bit sh;
    seed = $urandom(63);
    sh = 0;
    // shadow slot of a deferred jump: register, pipeline or external op
    for (int i = 0; i < 2048; i++) begin
      op = $urandom_range(9, 0);
      if ((sh && op != 1 && op != 7) || (i == 2047 && op == 6)) op = 3;
      sh = (op == 6);
      pm[i] = {4'(op), 18'($urandom)};
    end
    for (int i = 0; i < 7; i++) pm[i] = pro[i];
    run_phase(0);
    run_phase(1);
    finish_test();
  end

  // two phases of 600 ticks fit well inside this span
  initial begin
    #(4 * 80000);
    err_count++;
    finish_test();
  end
endmodule
`default_nettype wire
